// ==== common/zslc_pkg.sv ====
// zslc_pkg: shared modes, symbol codes and substitution tables of the line coder
package zslc_pkg;
  // ==========================================================================
  // modes and symbols
  // ==========================================================================
  localparam logic [1:0] MODE_B8ZS = 2'h0;
  localparam logic [1:0] MODE_B6ZS = 2'h1;
  localparam logic [1:0] MODE_HDB3 = 2'h2;
  // symbol is {positive rail, negative rail}
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_NEG = 2'h1;
  localparam logic [1:0] SYM_POS = 2'h2;
  localparam logic [3:0] RUN_B8ZS = 4'h8;
  localparam logic [3:0] RUN_B6ZS = 4'h6;
  localparam logic [3:0] RUN_HDB3 = 4'h4;
  localparam logic [2:0] WIN_LAST = 3'h7;
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================================
  // substitution patterns, first symbol in the top two bits, zero padded
  // ==========================================================================
  localparam logic [15:0] PAT_B8ZS_POS = 16'h0248;
  localparam logic [15:0] PAT_B8ZS_NEG = 16'h0184;
  localparam logic [15:0] PAT_B6ZS_POS = 16'h2490;
  localparam logic [15:0] PAT_B6ZS_NEG = 16'h1890;
  localparam logic [15:0] PAT_HDB3_POS_ODD = 16'h0200;
  localparam logic [15:0] PAT_HDB3_POS_EVEN = 16'h4100;
  localparam logic [15:0] PAT_HDB3_NEG_ODD = 16'h0100;
  localparam logic [15:0] PAT_HDB3_NEG_EVEN = 16'h8200;

  function automatic logic [3:0] zslc_run_len(input logic [1:0] mode);
    case (mode)
      MODE_B6ZS: return RUN_B6ZS;
      MODE_HDB3: return RUN_HDB3;
      default: return RUN_B8ZS;
    endcase
  endfunction : zslc_run_len

  function automatic logic [15:0] zslc_pattern(input logic [1:0] mode, input logic pol_pos,
                                               input logic odd);
    case (mode)
      MODE_B6ZS: return pol_pos ? PAT_B6ZS_POS : PAT_B6ZS_NEG;
      MODE_HDB3: begin
        if (pol_pos) return odd ? PAT_HDB3_POS_ODD : PAT_HDB3_POS_EVEN;
        return odd ? PAT_HDB3_NEG_ODD : PAT_HDB3_NEG_EVEN;
      end
      default: return pol_pos ? PAT_B8ZS_POS : PAT_B8ZS_NEG;
    endcase
  endfunction : zslc_pattern

  // polarity of the last nonzero symbol of the pattern chosen
  function automatic logic zslc_pol_after(input logic [1:0] mode, input logic pol_pos,
                                          input logic odd);
    case (mode)
      MODE_B6ZS: return 1'b0;
      MODE_HDB3: return odd ? pol_pos : !pol_pos;
      default: return pol_pos;
    endcase
  endfunction : zslc_pol_after

  // mask over the first len symbols of a 16-bit pattern
  function automatic logic [15:0] zslc_sym_mask(input logic [3:0] len);
    return ~(16'hFFFF >> {len, 1'b0});
  endfunction : zslc_sym_mask
endpackage : zslc_pkg

// ==== verilog/zslc_fifo.sv ====
// zslc_fifo: small synchronous fifo with valid and ready on both sides
module zslc_fifo #(
  parameter int WIDTH = zslc_pkg::FIFO_WIDTH,
  parameter int DEPTH = zslc_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;

  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (do_wr && !do_rd) next_count = count + 1'b1;
    if (do_rd && !do_wr) next_count = count - 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (do_wr) mem[wr_ptr] <= wr_data_in;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      wr_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
    end else begin
      if (do_wr) wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      wr_ready_out <= (next_count != FULL_CNT);
      rd_valid_out <= (next_count != '0);
    end
  end
endmodule : zslc_fifo

// ==== verilog/zslc_decoder.sv ====
// zslc_decoder: bipolar rails back to nrz, with substitution and error detection
module zslc_decoder (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] mode_in,
  input wire logic pos_in,
  input wire logic neg_in,
  input wire logic valid_in,
  output logic nrz_out,
  output logic nrz_valid_out,
  output logic sub_detect_out,
  output logic bv_flag_out,
  output logic conflict_out
);
  logic [15:0] win;
  logic [2:0] fill;
  logic full;
  logic [3:0] skip;
  logic last_pos;
  logic [3:0] len;
  logic [15:0] mask;
  logic hit_even;
  logic hit_odd;
  logic [1:0] sym_in;
  logic [1:0] oldest;

  // a conflicting pair counts as no pulse in the data path
  assign sym_in = (pos_in && neg_in) ? zslc_pkg::SYM_ZERO : {pos_in, neg_in};
  assign oldest = win[15:14];
  assign len = zslc_pkg::zslc_run_len(mode_in);
  assign mask = zslc_pkg::zslc_sym_mask(len);
  assign hit_even = (win & mask) == (zslc_pkg::zslc_pattern(mode_in, last_pos, 1'b0) & mask);
  assign hit_odd = (win & mask) == (zslc_pkg::zslc_pattern(mode_in, last_pos, 1'b1) & mask);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      win <= 16'h0000;
      fill <= 3'h0;
      full <= 1'b0;
      skip <= 4'h0;
      last_pos <= 1'b0;
      nrz_out <= 1'b0;
      nrz_valid_out <= 1'b0;
      sub_detect_out <= 1'b0;
      bv_flag_out <= 1'b0;
      conflict_out <= 1'b0;
    end else begin
      nrz_valid_out <= 1'b0;
      sub_detect_out <= 1'b0;
      bv_flag_out <= 1'b0;
      conflict_out <= valid_in && pos_in && neg_in;
      if (valid_in) begin
        win <= {win[13:0], sym_in};
        if (!full) begin
          fill <= fill + 1'b1;
          full <= (fill == zslc_pkg::WIN_LAST);
        end else begin
          nrz_valid_out <= 1'b1;
          if (skip != 4'h0) begin
            nrz_out <= 1'b0;
            skip <= skip - 1'b1;
          end else if (hit_even || hit_odd) begin
            nrz_out <= 1'b0;
            sub_detect_out <= 1'b1;
            skip <= len - 1'b1;
            last_pos <= zslc_pkg::zslc_pol_after(mode_in, last_pos, hit_odd);
          end else begin
            nrz_out <= (oldest != zslc_pkg::SYM_ZERO);
            if (oldest != zslc_pkg::SYM_ZERO) begin
              last_pos <= (oldest == zslc_pkg::SYM_POS);
              bv_flag_out <= ((oldest == zslc_pkg::SYM_POS) == last_pos);
            end
          end
        end
      end
    end
  end
endmodule : zslc_decoder

// ==== verilog/zslc_top.sv ====
// zslc_top: zero substitution line coder, encoder with input fifo and decoder
// ============================================================================
// ============================================================================
module zslc_top (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] mode_in,
  input wire logic nrz_data_in,
  input wire logic nrz_valid_in,
  output logic nrz_ready_out,
  input wire logic line_ready_in,
  output logic encoder_positive_rail_out,
  output logic encoder_negative_rail_out,
  output logic enc_symbol_valid_out,
  output logic [1:0] active_mode_out,
  input wire logic line_pos_in,
  input wire logic line_neg_in,
  input wire logic line_valid_in,
  output logic nrz_data_out,
  output logic nrz_valid_out,
  output logic sub_detect_out,
  output logic bipolar_violation_flag_out,
  output logic rail_conflict_out
);
  typedef enum logic [2:0] {
    ZSLC_FILL = 3'h1,
    ZSLC_AMI = 3'h2,
    ZSLC_SUB = 3'h4
  } zslc_enc_st_t;

  zslc_enc_st_t state;
  logic [1:0] mode;
  logic mode_taken;
  logic [7:0] dly;
  logic [2:0] fill;
  logic [15:0] pat;
  logic [3:0] sub_left;
  logic last_pos;
  logic ones_odd;
  logic fifo_valid;
  logic fifo_data;
  logic pop;
  logic emit;
  logic start;
  logic zero_run;
  logic [3:0] run_len;
  logic [7:0] run_mask;
  logic [15:0] new_pat;
  logic [1:0] next_sym;

  // ==========================================================================
  // input buffering
  // ==========================================================================
  zslc_fifo #(
    .WIDTH(zslc_pkg::FIFO_WIDTH),
    .DEPTH(zslc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_data_in(nrz_data_in),
    .wr_valid_in(nrz_valid_in),
    .wr_ready_out(nrz_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(pop)
  );

  // ==========================================================================
  // mode capture
  // ==========================================================================
  // mode is a strap: taken once after reset so the code never changes mid-run
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      mode <= zslc_pkg::MODE_B8ZS;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode <= (mode_in == zslc_pkg::MODE_B6ZS || mode_in == zslc_pkg::MODE_HDB3) ?
              mode_in : zslc_pkg::MODE_B8ZS;
      mode_taken <= 1'b1;
    end
  end

  assign active_mode_out = mode;

  // ==========================================================================
  // lookahead and substitution decision
  // ==========================================================================
  // the line side stalls the encoder; during fill no symbol is owed
  assign pop = fifo_valid && (state == ZSLC_FILL || line_ready_in);
  assign emit = pop && (state != ZSLC_FILL);
  assign run_len = zslc_pkg::zslc_run_len(mode);
  assign run_mask = ~(8'hFF >> run_len);
  assign zero_run = (dly & run_mask) == 8'h00;
  assign start = emit && (state == ZSLC_AMI) && zero_run;
  // b8zs patterns and the positive b6zs pattern as tabled only break polarity at their first violation slot; the negative b6zs one breaks at both
  assign new_pat = zslc_pkg::zslc_pattern(mode, last_pos, ones_odd);

  always_comb begin
    next_sym = zslc_pkg::SYM_ZERO;
    if (state == ZSLC_SUB) begin
      next_sym = pat[15:14];
    end else if (start) begin
      next_sym = new_pat[15:14];
    end else if (dly[7]) begin
      next_sym = last_pos ? zslc_pkg::SYM_NEG : zslc_pkg::SYM_POS;
    end
  end

  // ==========================================================================
  // encoder state
  // ==========================================================================
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state <= ZSLC_FILL;
      fill <= 3'h0;
    end else begin
      case (state)
        ZSLC_FILL: begin
          if (pop) begin
            fill <= fill + 1'b1;
            if (fill == zslc_pkg::WIN_LAST) state <= ZSLC_AMI;
          end
        end
        ZSLC_AMI: begin
          if (start) state <= ZSLC_SUB;
        end
        ZSLC_SUB: begin
          if (emit && sub_left == 4'h1) state <= ZSLC_AMI;
        end
        default: state <= ZSLC_FILL;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      dly <= 8'h00;
    end else if (pop) begin
      dly <= {dly[6:0], fifo_data};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pat <= 16'h0000;
      sub_left <= 4'h0;
    end else if (start) begin
      pat <= {new_pat[13:0], 2'h0};
      sub_left <= run_len - 1'b1;
    end else if (emit && state == ZSLC_SUB) begin
      pat <= {pat[13:0], 2'h0};
      sub_left <= sub_left - 1'b1;
    end
  end

  // starts negative so the very first one goes out positive unless hdb3 sends an odd number of b00v before it
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      last_pos <= 1'b0;
      ones_odd <= 1'b0;
    end else if (start) begin
      last_pos <= zslc_pkg::zslc_pol_after(mode, last_pos, ones_odd);
      ones_odd <= 1'b0;
    end else if (emit && state == ZSLC_AMI && dly[7]) begin
      last_pos <= !last_pos;
      ones_odd <= !ones_odd;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      encoder_positive_rail_out <= 1'b0;
      encoder_negative_rail_out <= 1'b0;
      enc_symbol_valid_out <= 1'b0;
    end else begin
      encoder_positive_rail_out <= emit && next_sym[1];
      encoder_negative_rail_out <= emit && next_sym[0];
      enc_symbol_valid_out <= emit;
    end
  end

  // ==========================================================================
  // decoder
  // ==========================================================================
  zslc_decoder u_decoder (
    .clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .mode_in(mode),
    .pos_in(line_pos_in),
    .neg_in(line_neg_in),
    .valid_in(line_valid_in),
    .nrz_out(nrz_data_out),
    .nrz_valid_out(nrz_valid_out),
    .sub_detect_out(sub_detect_out),
    .bv_flag_out(bipolar_violation_flag_out),
    .conflict_out(rail_conflict_out)
  );

  // ==========================================================================
  // checking helpers
  // ==========================================================================
  logic out_plain;
  logic out_bit;
  logic prev_pos;
  logic [15:0] exp_pat;
  logic [3:0] exp_cnt;
  logic start_odd;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      out_plain <= 1'b0;
      out_bit <= 1'b0;
      prev_pos <= 1'b0;
      exp_pat <= 16'h0000;
      exp_cnt <= 4'h0;
      start_odd <= 1'b0;
    end else begin
      if (emit) begin
        out_plain <= (state == ZSLC_AMI) && !start;
        out_bit <= dly[7];
      end
      if (enc_symbol_valid_out && (encoder_positive_rail_out || encoder_negative_rail_out)) begin
        prev_pos <= encoder_positive_rail_out;
      end
      if (start) begin
        exp_pat <= new_pat;
        exp_cnt <= run_len;
        start_odd <= ones_odd;
      end else if (enc_symbol_valid_out && exp_cnt != 4'h0) begin
        exp_pat <= {exp_pat[13:0], 2'h0};
        exp_cnt <= exp_cnt - 1'b1;
      end
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_rail_exclusive: assert property (
    !(encoder_positive_rail_out && encoder_negative_rail_out))
    else $error("both encoder rails high");

  chk_idle_rails_low: assert property (
    !enc_symbol_valid_out |-> !encoder_positive_rail_out && !encoder_negative_rail_out)
    else $error("rail pulse without a symbol");

  chk_ami_alternate: assert property (
    enc_symbol_valid_out && out_plain && out_bit
    |-> (encoder_positive_rail_out != encoder_negative_rail_out)
        && (encoder_positive_rail_out != prev_pos))
    else $error("plain one did not alternate");

  chk_zero_silent: assert property (
    enc_symbol_valid_out && out_plain && !out_bit
    |-> !encoder_positive_rail_out && !encoder_negative_rail_out)
    else $error("plain zero produced a pulse");

  chk_sub_sequence: assert property (
    enc_symbol_valid_out && exp_cnt != 4'h0
    |-> {encoder_positive_rail_out, encoder_negative_rail_out} == exp_pat[15:14])
    else $error("substitution symbol mismatch");

  chk_sub_starts_run: assert property (
    start |=> enc_symbol_valid_out && exp_cnt == run_len && !out_plain)
    else $error("substitution did not start at the run");

  chk_b8zs_viol: assert property (
    enc_symbol_valid_out && mode == zslc_pkg::MODE_B8ZS && exp_cnt == 4'h5
    |-> encoder_positive_rail_out == prev_pos
        && (encoder_positive_rail_out || encoder_negative_rail_out))
    else $error("b8zs fourth symbol is not a violation");

  chk_b6zs_viol: assert property (
    enc_symbol_valid_out && mode == zslc_pkg::MODE_B6ZS && exp_cnt == 4'h5
    |-> encoder_positive_rail_out == prev_pos
        && (encoder_positive_rail_out || encoder_negative_rail_out))
    else $error("b6zs second symbol is not a violation");

  chk_hdb3_viol: assert property (
    enc_symbol_valid_out && mode == zslc_pkg::MODE_HDB3 && exp_cnt == 4'h1
    |-> encoder_positive_rail_out == prev_pos
        && (encoder_positive_rail_out || encoder_negative_rail_out))
    else $error("hdb3 fourth symbol is not a violation");

  chk_hdb3_lead: assert property (
    enc_symbol_valid_out && mode == zslc_pkg::MODE_HDB3 && exp_cnt == 4'h4
    |-> (start_odd ? !(encoder_positive_rail_out || encoder_negative_rail_out)
                   : (encoder_positive_rail_out != prev_pos)
                     && (encoder_positive_rail_out || encoder_negative_rail_out)))
    else $error("hdb3 lead symbol has the wrong form");

  chk_parity_clear: assert property (
    start |=> !ones_odd && last_pos == $past(zslc_pkg::zslc_pol_after(mode, last_pos, ones_odd)))
    else $error("tracking not updated after substitution");

  chk_mode_hold: assert property (
    mode_taken && $past(mode_taken) |-> $stable(mode) && mode != 2'h3)
    else $error("active code changed");

  chk_conflict_err: assert property (
    line_valid_in && line_pos_in && line_neg_in |=> rail_conflict_out)
    else $error("rail conflict not flagged");

  chk_dec_sub_zero: assert property (
    sub_detect_out |-> nrz_valid_out && !nrz_data_out && !bipolar_violation_flag_out)
    else $error("recognised pattern not decoded as zeros");

  chk_dec_bv_one: assert property (
    bipolar_violation_flag_out |-> nrz_valid_out && nrz_data_out)
    else $error("violation flag without a decoded one");

  cov_b8zs_sub: cover property (start && mode == zslc_pkg::MODE_B8ZS);
  cov_hdb3_b00v: cover property (start && mode == zslc_pkg::MODE_HDB3 && !ones_odd);
  cov_dec_detect: cover property (sub_detect_out ##1 nrz_valid_out [*3]);
  cov_dec_bv: cover property (bipolar_violation_flag_out);
  cov_b6zs_sub: cover property (start && mode == zslc_pkg::MODE_B6ZS);
endmodule : zslc_top

// ==== dv/zslc_line_model.sv ====
// zslc_line_model: trunk line partner, loops encoder symbols back to the decoder
module zslc_line_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic invert_in,
  input wire logic conflict_req_in,
  input wire logic tx_pos_in,
  input wire logic tx_neg_in,
  input wire logic tx_valid_in,
  output logic line_ready_out,
  output logic rx_pos_out,
  output logic rx_neg_out,
  output logic rx_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pend = 1'h0;
  // ==========================================================================
  // line side
  // ==========================================================================
  assign line_ready_out = !stall_in;
  always @(posedge clk_in) begin
    if (conflict_req_in) begin
      pend <= 1'h1;
    end
    rx_valid_out <= tx_valid_in;
    if (tx_valid_in) begin
      if (pend) begin
        rx_pos_out <= 1'h1;
        rx_neg_out <= 1'h1;
        pend <= 1'h0;
      end else begin
        // rails pass straight through, or swapped while invert_in is high
        rx_pos_out <= invert_in ? tx_neg_in : tx_pos_in;
        rx_neg_out <= invert_in ? tx_pos_in : tx_neg_in;
      end
    end else begin
      // unqualified rails wander, never hold the last symbol
      rx_pos_out <= (rx_pos_out !== 1'h1);
      rx_neg_out <= (rx_neg_out !== 1'h1);
    end
  end
endmodule : zslc_line_model

// ==== dv/zslc_top_test.sv ====
// zslc_top_test: self-checking bench of the zero substitution line coder
module zslc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // signals and instances
  // ==========================================================================
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [1:0] mode = 2'h0;
  logic din = 1'h0;
  logic dvalid = 1'h0;
  logic stall = 1'h0;
  logic inv = 1'h0;
  logic conf = 1'h0;
  logic rdy, lrdy, ep, en, ev, lp, ln, lv, dout, dov, sub, bv, rc;
  logic [1:0] amode;
  int n_fail = 0;
  int checked = 0;
  int n_sub, n_bv, n_rc;
  string enc_s, dec_s;
  initial begin
    forever #5 clk = ~clk;
  end
  zslc_top DUT (.sys_clk_in(clk), .nrst_in(nrst), .mode_in(mode), .nrz_data_in(din),
    .nrz_valid_in(dvalid), .nrz_ready_out(rdy), .line_ready_in(lrdy),
    .encoder_positive_rail_out(ep), .encoder_negative_rail_out(en),
    .enc_symbol_valid_out(ev), .active_mode_out(amode), .line_pos_in(lp), .line_neg_in(ln),
    .line_valid_in(lv), .nrz_data_out(dout), .nrz_valid_out(dov), .sub_detect_out(sub),
    .bipolar_violation_flag_out(bv), .rail_conflict_out(rc));
  zslc_line_model line (.clk_in(clk), .stall_in(stall), .invert_in(inv),
    .conflict_req_in(conf), .tx_pos_in(ep), .tx_neg_in(en), .tx_valid_in(ev),
    .line_ready_out(lrdy), .rx_pos_out(lp), .rx_neg_out(ln), .rx_valid_out(lv));
  // ==========================================================================
  // monitor, sampled mid-cycle so flop updates never race it
  // ==========================================================================
  function automatic string sym(input logic p, input logic n);
    if (p === 1'h1) return (n === 1'h1) ? "X" : "+";
    return (n === 1'h1) ? "-" : "0";
  endfunction : sym
  always @(negedge clk) begin
    if (ev === 1'h1) enc_s = {enc_s, sym(ep, en)};
    if (dov === 1'h1) dec_s = {dec_s, (dout === 1'h1) ? "1" : "0"};
    n_sub += (sub === 1'h1);
    n_bv += (bv === 1'h1);
    n_rc += (rc === 1'h1);
  end
  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic cmp_str(input string got, input string exp, input string what);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %s exp %s", $time, what, got, exp);
    end
  endtask : cmp_str
  task automatic cmp_int(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : cmp_int
  task automatic cmp_lv(input logic [1:0] got, input logic [1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_lv
  task automatic do_reset(input logic [1:0] m);
    nrst = 1'h0;
    mode = m;
    dvalid = 1'h0;
    repeat (6) @(posedge clk);
    #1;
    enc_s = "";
    dec_s = "";
    n_sub = 0;
    n_bv = 0;
    n_rc = 0;
    nrst = 1'h1;
  endtask : do_reset
  task automatic send(input string b);
    int w;
    for (int i = 0; i < b.len(); i++) begin
      din = (b[i] == "1");
      dvalid = 1'h1;
      w = 0;
      while (rdy !== 1'h1 && w < 100) begin
        @(posedge clk);
        #1;
        w++;
      end
      if (rdy !== 1'h1) begin
        n_fail++;
        $display("MISMATCH %0t input never ready", $time);
      end
      @(posedge clk);
      #1;
    end
    dvalid = 1'h0;
  endtask : send
  // decoder trails the encoder by its eight-symbol window
  task automatic wait_len(input int n);
    int w;
    w = 0;
    while ((enc_s.len() < n || dec_s.len() + 8 < n) && w < 300) begin
      @(posedge clk);
      w++;
    end
    if (enc_s.len() < n || dec_s.len() + 8 < n) begin
      n_fail++;
      $display("MISMATCH %0t stream never completed", $time);
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : wait_len
  // trailing ones push the data out of the lookahead, which has no flush
  task automatic run_stream(input logic [1:0] m, input string b, input string exp, input int s);
    do_reset(m);
    send({b, "1111111111111111"});
    wait_len(b.len() + 8);
    cmp_str(enc_s.substr(0, exp.len() - 1), exp, "line symbols");
    cmp_str(dec_s.substr(0, b.len() - 1), b, "decoded bits");
    cmp_int(n_sub, s, "patterns seen");
    cmp_int(n_bv, 0, "violations");
    cmp_lv(amode, m, "mode");
  endtask : run_stream
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic test_b8zs;
    run_stream(2'h0, "1000000001000000001",
      "+000+-0+0-000-+0-0+", 2);
  endtask : test_b8zs
  task automatic test_b6zs;
    run_stream(2'h1, "1000000110000001", "+0+-0+-+-0-+0+-+", 2);
  endtask : test_b6zs
  task automatic test_hdb3;
    run_stream(2'h2, "000010000110000110000100001",
      "+00+-000-+-+00+-+-00-+000+-", 5);
  endtask : test_hdb3
  task automatic test_stall;
    int taken;
    logic r;
    do_reset(2'h3);
    stall = 1'h1;
    din = 1'h1;
    dvalid = 1'h1;
    taken = 0;
    repeat (40) begin
      r = rdy;
      @(posedge clk);
      #1;
      taken += (r === 1'h1);
    end
    dvalid = 1'h0;
    cmp_int(taken, 16, "bits taken while stalled");
    cmp_lv({1'h0, rdy}, 2'h0, "ready when full");
    cmp_int(enc_s.len(), 0, "symbols while stalled");
    cmp_lv(amode, zslc_pkg::MODE_B8ZS, "mode three");
    stall = 1'h0;
    wait_len(8);
    cmp_str(enc_s, "+-+-+-+-", "plain ones");
  endtask : test_stall
  task automatic test_faults;
    do_reset(2'h0);
    send("111111111111");
    inv = 1'h1;
    @(posedge clk);
    #1;
    send("11111111");
    conf = 1'h1;
    @(posedge clk);
    #1;
    conf = 1'h0;
    send("1111111111111111");
    wait_len(28);
    inv = 1'h0;
    cmp_int(n_bv, 2, "violations flagged");
    cmp_int(n_rc, 1, "rail conflicts");
  endtask : test_faults
  task automatic end_of_test;
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    test_b8zs();
    test_b6zs();
    test_hdb3();
    test_stall();
    test_faults();
    end_of_test();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : zslc_top_test
